// file: dv/supply_partner.sv
/*
  Far-side model: the low-speed oscillator pin and the two supply comparators.
  Assumes the testbench calls its tasks from its own clocked sequence.
*/
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// oscillator and comparator levels
module supply_partner #(
  parameter int OSC_HALF_NS = 160
) (
  input  wire logic hclk,
  output var logic  lowspeed_osc_clock,
  output var logic  cmp1_level,
  output var logic  cmp2_level
);
  initial begin
    lowspeed_osc_clock = 1'b0;
    cmp1_level         = 1'b1;
    cmp2_level         = 1'b1;
  end

  // free running: gating it is the block's job, through its stop bit
  always #(OSC_HALF_NS) lowspeed_osc_clock = ~lowspeed_osc_clock;

  task automatic set_level(input int idx, input logic v);
    @(posedge hclk);
    if (idx == 1) cmp1_level <= v;
    else cmp2_level <= v;
  endtask

  // a dip shorter than one sample period must not reach the outputs
  task automatic pulse(input int idx, input logic v, input int cyc);
    set_level(idx, v);
    repeat (cyc - 1) @(posedge hclk);
    set_level(idx, ~v);
  endtask
endmodule // supply_partner

`default_nettype wire

// file: dv/tb_top.sv
/*
  Self-checking bench: register table, filter timing per divider, glitch, bypass, monitor 2.
  Assumes a zero-wait AHB-Lite slave and an oscillator at one eighth of hclk.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

// ==========================================================================
// top
module tb_top;
  localparam int OSC_CYC = 8;
  localparam int SETTLE  = 20;
  typedef struct { bit wr; logic [7:0] a; logic [31:0] d; } row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        osc, cmp1, cmp2, internal_reset_n, irq;
  int          n_fail = 0;
  int          comparisons = 0;
  int          lat, p, n;
  row_t rows [16] = '{'{1'b0, 8'h00, 32'h200}, '{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h08, 32'h300},
    '{1'b0, 8'h0C, 32'h0}, '{1'b0, 8'h10, 32'h0}, '{1'b1, 8'h10, 32'hFFFFFFFF}, '{1'b0, 8'h10, 32'h0},
    '{1'b1, 8'h0C, 32'hFFFFFFFF}, '{1'b0, 8'h0C, 32'h3}, '{1'b1, 8'h04, 32'hFFFFFFFF},
    '{1'b0, 8'h04, 32'h1F3}, '{1'b1, 8'h04, 32'h0}, '{1'b1, 8'h00, 32'h3FF}, '{1'b0, 8'h00, 32'h3F7},
    '{1'b1, 8'h00, 32'h200}, '{1'b1, 8'h0C, 32'h0}};

  supply_monitor_filter_reset u_supply_monitor_filter_reset (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lowspeed_osc_clock(osc), .cmp1_level(cmp1),
    .cmp2_level(cmp2), .internal_reset_n(internal_reset_n), .irq(irq));
  supply_partner u_supply_partner (.hclk(hclk), .lowspeed_osc_clock(osc), .cmp1_level(cmp1), .cmp2_level(cmp2));

  always #20 hclk = ~hclk;

  task automatic stop_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin n_fail++; stop_test; end
  endtask

  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask

  task automatic wait_for(input bit use_irq, input logic v, input int bound);
    lat = 0;
    while (((use_irq ? irq : internal_reset_n) !== v) && lat < bound) begin @(posedge hclk); lat++; end
    if ((use_irq ? irq : internal_reset_n) !== v) begin n_fail++; $display("timeout t=%0t", $time); stop_test; end
  endtask

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK({internal_reset_n, irq, hreadyout, hresp}, 4'hA)
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) `CHK(q, rows[i].d)
    end
    $display("test registers done");
    bus(1'b1, 8'h00, 32'h100);
    repeat (SETTLE) @(posedge hclk);
    for (int c = 0; c < 4; c++) begin
      p = OSC_CYC << c;
      bus(1'b1, 8'h00, 32'h140 | 32'(c << 4));
      u_supply_partner.set_level(1, 1'b1);
      wait_for(1'b0, 1'b1, 4 * p + 20);
      repeat (4 * p) @(posedge hclk);
      bus(1'b1, 8'h00, 32'h141 | 32'(c << 4));
      u_supply_partner.set_level(1, 1'b0);
      wait_for(1'b0, 1'b0, 2 * p + 20);
      `CHK(lat >= p && lat <= 2 * p + 8, 1'b1)
    end
    bus(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h202)
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h200)
    $display("test divider timing done");
    u_supply_partner.set_level(1, 1'b1);
    wait_for(1'b0, 1'b1, 200);
    bus(1'b1, 8'h00, 32'h150);
    repeat (4 * 16) @(posedge hclk);
    bus(1'b1, 8'h00, 32'h151);
    u_supply_partner.pulse(1, 1'b0, 6);
    n = 0;
    repeat (48) begin @(posedge hclk); if (internal_reset_n !== 1'b1) n++; end
    `CHK(n, 0)
    $display("test glitch done");
    bus(1'b1, 8'h00, 32'h1C2);
    bus(1'b1, 8'h00, 32'h1C3);
    u_supply_partner.pulse(1, 1'b0, 3);
    wait_for(1'b0, 1'b0, 10);
    `CHK(lat <= 6, 1'b1)
    wait_for(1'b0, 1'b1, 10);
    $display("test bypass done");
    bus(1'b1, 8'h00, 32'h100);
    bus(1'b1, 8'h04, 32'h183);
    bus(1'b1, 8'h0C, 32'h1);
    u_supply_partner.set_level(2, 1'b0);
    wait_for(1'b1, 1'b1, 12);
    `CHK(internal_reset_n, 1'b1)
    bus(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h103)
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({irq, q}, {1'b0, 32'h102})
    bus(1'b1, 8'h0C, 32'h0);
    u_supply_partner.set_level(2, 1'b1);
    repeat (10) @(posedge hclk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h302)
    u_supply_partner.set_level(2, 1'b0);
    repeat (10) @(posedge hclk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({irq, q}, {1'b0, 32'h103})
    bus(1'b1, 8'h04, 32'h1C3);
    wait_for(1'b0, 1'b0, 8);
    `CHK(irq, 1'b0)
    $display("test monitor 2 done");
    // mid-run reset: the pending monitor 2 reset request must drop and the registers return to reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    `CHK({internal_reset_n, irq, q}, {2'b10, 32'h200})
    $display("test reset done");
    stop_test;
  end
endmodule // tb_top

`default_nettype wire

// file: hw/supmon_defs.svh
/*
  Register offsets, field positions and reset values of the supply monitor filter block.
  Assumes it is included by bare name before any use.
*/
`ifndef SUPMON_DEFS_SVH
`define SUPMON_DEFS_SVH

// ==========================================================================
// register byte offsets (low address bits only are decoded)
`define SM_ADDR_W       8
`define SM_ADDR_CTRL1   8'h00
`define SM_ADDR_CTRL2   8'h04
`define SM_ADDR_STATUS  8'h08
`define SM_ADDR_MASK    8'h0C

// ==========================================================================
// control field positions, same layout for both monitors except spare and osc stop, which only CTRL1 has
`define SM_B_EN         0
`define SM_B_FDIS       1
`define SM_B_SPARE      2
`define SM_B_DIV_LO     4
`define SM_B_DIV_HI     5
`define SM_B_MODE       6
`define SM_B_COND       7
`define SM_B_DET        8
`define SM_B_OSC_STOP   9

// ==========================================================================
// status and mask field positions
`define SM_ST_W         2
`define SM_ST_MON2      0
`define SM_ST_MON1      1
`define SM_ST_LVL1      8
`define SM_ST_LVL2      9

// ==========================================================================
// reset values and the htrans bit that flags a transfer
`define SM_OSC_STOP_RST 1'b1
`define SM_LVL_RST      1'b1
`define SM_ST_RST       2'h0
`define SM_HTRANS_NSEQ  1

`endif

// file: hw/supmon_pkg.sv
/*
  Types shared by the supply monitor filter block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package supmon_pkg;

  // per-monitor control bits as software programs them
  typedef struct packed {
    logic       det_enable;
    logic       cond_sel;
    logic       mode;
    logic [1:0] div;
    logic       spare;
    logic       filter_disable;
    logic       enable;
  } mon_ctrl_t;

  localparam mon_ctrl_t MON_CTRL_RST = '0;

  // last count of the sample divider: 00 -> /1 ... 11 -> /8
  function automatic logic [2:0] div_max(input logic [1:0] sel);
    logic [3:0] ratio;
    ratio   = 4'h1 << sel;
    div_max = 3'(ratio - 4'h1);
  endfunction

endpackage

// file: hw/supply_monitor_filter_reset.sv
/*
  Supply monitor glitch filter, reset and interrupt logic with an AHB-Lite register slave.
  Assumes comparator outputs and the low-speed oscillator arrive asynchronously to hclk,
  and that software follows the documented programming order.
*/
`timescale 1ns/10ps
`default_nettype none
`include "supmon_defs.svh"

// ==========================================================================
// one monitor: synchroniser, sample divider and two-sample filter
module sample_filter (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       osc_edge,
  input  wire logic       fdis,
  input  wire logic [1:0] div_sel,
  input  wire logic       level_async,
  output logic            sync_level,
  output logic            sample_reg,
  output logic            filt_level,
  output logic            tick,
  output logic [2:0]      cnt_reg
);
  logic [2:0] sync_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_ff    <= {3{`SM_LVL_RST}};
      sync_level <= `SM_LVL_RST;
    end else begin
      sync_ff <= {sync_ff[1:0], level_async};
      if (sync_ff[1] == sync_ff[2]) begin
        sync_level <= sync_ff[2];
      end
    end
  end

  // compare with >= so that a smaller ratio written mid-count does not wrap the counter first
  assign tick = osc_edge && !fdis && (cnt_reg >= supmon_pkg::div_max(div_sel)); // [R2] [R14]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (fdis || tick) begin
      cnt_reg <= '0;
    end else if (osc_edge) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_reg <= `SM_LVL_RST;
    end else if (tick) begin
      sample_reg <= sync_level; // [R3]
    end
  end

  // a lone differing sample leaves the filtered level untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_level <= `SM_LVL_RST;
    end else if (fdis) begin
      filt_level <= sync_level; // [R1]
    end else if (tick && sample_reg == sync_level) begin
      filt_level <= sync_level; // [R4] [R16]
    end
  end
endmodule // sample_filter

// What this block does
// R1: filter runs only while the monitor's filter-disable bit is 0; 1 bypasses it.
// R2: sample clock is the low-speed oscillator divided by 1, 2, 4 or 8.
// R3: comparator level is captured once each sample period while filtering.
// R4: reset or monitor 2 interrupt follows only after two consecutive matching samples.
// R5: software leaving stop via monitor 1 reset sets its filter-disable bit.
// R6: software leaving stop via monitor 2 sets its filter-disable bit.
// R7: software enables detector 1, waits settling, then configures monitor 1.
// R8: with filter, software picks divider, then writes filter-disable as 0.
// R9: without filter, software sets condition select, then filter-disable to 1.
// R10: software then sets reset mode, then clears the spare bit 2.
// R11: with filter, software starts oscillator and waits four sample periods.
// R12: software sets monitor 1 reset enable last.
// R13: with reset enable 0, divider, disable and mode may share one write.
// R14: divider code 00,01,10,11 means divide by 1,2,4,8.
// R15: monitor 2 mode bit selects interrupt at 0, reset at 1.
// R16: filtered level holds until two consecutive samples agree.
module supply_monitor_filter_reset (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        lowspeed_osc_clock,
  input  wire logic        cmp1_level,
  input  wire logic        cmp2_level,
  output logic             internal_reset_n,
  output logic             irq
);
  supmon_pkg::mon_ctrl_t      mon1_ctrl_reg;
  supmon_pkg::mon_ctrl_t      mon2_ctrl_reg;
  logic                       lowspeed_osc_stop_reg;
  logic [`SM_ST_W-1:0]        status_reg;
  logic [`SM_ST_W-1:0]        mask_reg;
  logic [`SM_ST_W-1:0]        status_set;
  logic [`SM_ADDR_W-1:0]      addr_reg;
  logic                       wr_reg;
  logic [2:0]                 osc_ff;
  logic                       osc_lvl_reg;
  logic                       osc_edge;
  logic                       mon1_reset_req;
  logic                       mon2_reset_req;
  logic                       mon2_prev_reg;
  logic                       mon1_prev_reg;
  logic [1:0]                 sync_lvl;
  logic [1:0]                 samp;
  logic [1:0]                 filt;
  logic [1:0]                 tick;
  logic [2:0]                 cnt [2];
  logic [1:0]                 fdis;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // oscillator edge detection, three-stage synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_ff      <= '0;
      osc_lvl_reg <= 1'b0;
    end else begin
      osc_ff <= {osc_ff[1:0], lowspeed_osc_clock};
      if (osc_ff[1] == osc_ff[2]) begin
        osc_lvl_reg <= osc_ff[2];
      end
    end
  end

  // a stopped oscillator gives no sample ticks, so the filter freezes
  assign osc_edge = (osc_ff[1] == osc_ff[2]) && osc_ff[2] && !osc_lvl_reg && !lowspeed_osc_stop_reg;

  // ==========================================================================
  // the two monitor filters
  assign fdis = {mon2_ctrl_reg.filter_disable, mon1_ctrl_reg.filter_disable};

  for (genvar m = 0; m < 2; m++) begin : g_mon
    sample_filter u_filter (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .osc_edge    (osc_edge),
      .fdis        (fdis[m]),
      .div_sel     ((m == 0) ? mon1_ctrl_reg.div : mon2_ctrl_reg.div),
      .level_async ((m == 0) ? cmp1_level : cmp2_level),
      .sync_level  (sync_lvl[m]),
      .sample_reg  (samp[m]),
      .filt_level  (filt[m]),
      .tick        (tick[m]),
      .cnt_reg     (cnt[m])
    );
  end

  // ==========================================================================
  // reset and interrupt generation; a low filtered level means supply below threshold
  assign mon1_reset_req = mon1_ctrl_reg.det_enable && mon1_ctrl_reg.enable && mon1_ctrl_reg.mode && !filt[0];
  assign mon2_reset_req = mon2_ctrl_reg.det_enable && mon2_ctrl_reg.enable && mon2_ctrl_reg.mode && !filt[1]; // [R15]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_reset_n <= 1'b1;
    end else begin
      internal_reset_n <= !(mon1_reset_req || mon2_reset_req); // [R4]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon1_prev_reg <= `SM_LVL_RST;
      mon2_prev_reg <= `SM_LVL_RST;
    end else begin
      mon1_prev_reg <= filt[0];
      mon2_prev_reg <= filt[1];
    end
  end

  // monitor 2 interrupt mode: crossing in the direction chosen by the condition bit
  always_comb begin
    status_set              = '0;
    status_set[`SM_ST_MON2] = mon2_ctrl_reg.det_enable && mon2_ctrl_reg.enable && !mon2_ctrl_reg.mode &&
                              (filt[1] != mon2_prev_reg) && (filt[1] == !mon2_ctrl_reg.cond_sel); // [R4] [R15]
    status_set[`SM_ST_MON1] = mon1_prev_reg && !filt[0];
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
      wr_reg   <= 1'b0;
      hrdata   <= '0;
    end else begin
      wr_reg <= 1'b0;
      if (hsel && hready && htrans[`SM_HTRANS_NSEQ]) begin
        addr_reg <= haddr[`SM_ADDR_W-1:0];
        wr_reg   <= hwrite;
        hrdata   <= '0;
        if (!hwrite) begin
          unique case (haddr[`SM_ADDR_W-1:0])
            `SM_ADDR_CTRL1:  hrdata <= {22'h0, lowspeed_osc_stop_reg, mon1_ctrl_reg.det_enable,
                                        mon1_ctrl_reg.cond_sel, mon1_ctrl_reg.mode, mon1_ctrl_reg.div, 1'b0,
                                        mon1_ctrl_reg.spare, mon1_ctrl_reg.filter_disable, mon1_ctrl_reg.enable};
            `SM_ADDR_CTRL2:  hrdata <= {23'h0, mon2_ctrl_reg.det_enable, mon2_ctrl_reg.cond_sel,
                                        mon2_ctrl_reg.mode, mon2_ctrl_reg.div, 2'h0,
                                        mon2_ctrl_reg.filter_disable, mon2_ctrl_reg.enable};
            `SM_ADDR_STATUS: hrdata <= {22'h0, filt[1], filt[0], 6'h0, status_reg};
            `SM_ADDR_MASK:   hrdata <= {30'h0, mask_reg};
            default:         hrdata <= '0;
          endcase
        end
      end
    end
  end

  // hsize is accepted but only whole-word writes are meaningful
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon1_ctrl_reg         <= supmon_pkg::MON_CTRL_RST;
      mon2_ctrl_reg         <= supmon_pkg::MON_CTRL_RST;
      lowspeed_osc_stop_reg <= `SM_OSC_STOP_RST;
      mask_reg              <= `SM_ST_RST;
    end else if (wr_reg) begin
      unique case (addr_reg)
        `SM_ADDR_CTRL1: begin
          mon1_ctrl_reg         <= {hwdata[`SM_B_DET], hwdata[`SM_B_COND], hwdata[`SM_B_MODE],
                                    hwdata[`SM_B_DIV_HI:`SM_B_DIV_LO], hwdata[`SM_B_SPARE],
                                    hwdata[`SM_B_FDIS], hwdata[`SM_B_EN]};
          lowspeed_osc_stop_reg <= hwdata[`SM_B_OSC_STOP];
        end
        `SM_ADDR_CTRL2: begin
          mon2_ctrl_reg <= {hwdata[`SM_B_DET], hwdata[`SM_B_COND], hwdata[`SM_B_MODE],
                            hwdata[`SM_B_DIV_HI:`SM_B_DIV_LO], 1'b0, hwdata[`SM_B_FDIS], hwdata[`SM_B_EN]};
        end
        `SM_ADDR_MASK: begin
          mask_reg <= hwdata[`SM_ST_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= `SM_ST_RST;
    end else if (wr_reg && addr_reg == `SM_ADDR_STATUS) begin
      status_reg <= (status_reg & ~hwdata[`SM_ST_W-1:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_reg | status_set) & mask_reg);
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_bypass_follows;
    fdis[0] && $past(fdis[0]) |-> filt[0] == $past(sync_lvl[0]);
  endproperty
  a_bypass_follows: assert property (p_bypass_follows) else $error("bypassed filter did not follow input"); // [R1]

  property p_tick_at_divide;
    tick[1] |-> osc_edge && !fdis[1] ##1 cnt[1] == 3'h0;
  endproperty
  a_tick_at_divide: assert property (p_tick_at_divide) else $error("sample tick off divider count"); // [R2]

  property p_div8_spacing;
    tick[0] && mon1_ctrl_reg.div == 2'h3 |-> cnt[0] == 3'h7;
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide by eight spacing broken"); // [R14]

  property p_sample_capture;
    tick[0] |=> samp[0] == $past(sync_lvl[0]);
  endproperty
  a_sample_capture: assert property (p_sample_capture) else $error("sample not captured on tick"); // [R3]

  property p_two_agree;
    !$past(fdis[1]) && $changed(filt[1]) |-> $past(tick[1]) && $past(samp[1]) == filt[1];
  endproperty
  a_two_agree: assert property (p_two_agree) else $error("filtered level changed without two samples"); // [R4]

  property p_hold_no_tick;
    !$past(tick[0]) && !$past(fdis[0]) |-> $stable(filt[0]);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("filtered level moved between ticks"); // [R16]

  property p_mon2_reset;
    mon2_reset_req |=> !internal_reset_n;
  endproperty
  a_mon2_reset: assert property (p_mon2_reset) else $error("monitor 2 reset mode did not assert reset"); // [R15]

  property p_mon2_int_sticky;
    status_set[`SM_ST_MON2] |=> status_reg[`SM_ST_MON2] && (!$past(mask_reg[`SM_ST_MON2]) || irq);
  endproperty
  a_mon2_int_sticky: assert property (p_mon2_int_sticky) else $error("monitor 2 event lost"); // [R4]

  c_mon1_reset:  cover property (mon1_reset_req ##1 !internal_reset_n);
  c_mon2_irq:    cover property (status_set[`SM_ST_MON2] ##1 irq);
  c_glitch_held: cover property (tick[0] && samp[0] != sync_lvl[0] ##1 $stable(filt[0]));
endmodule // supply_monitor_filter_reset
`default_nettype wire
